// ### gain_synth_cfg.sv
// Gain lock and synthesizer loop table configuration register block
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps

module gain_synth_cfg
  import gain_synth_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic [9:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic [1:0] radio_state_in,
  input  wire logic       preamble_err_zero_in,
  input  wire logic       preamble_det_in,
  input  wire logic       sync_det_in,
  output logic      [1:0] gain_mode_out,
  output logic            gain_lock_out,
  output logic      [1:0] loop_table_out,
  output logic            table_load_out,
  output logic      [7:0] tx_table_first_out,
  output logic      [7:0] tx_table_last_out,
  output logic      [5:0] rx_tune_a_out,
  output logic      [3:0] rx_tune_b_out
);

  typedef struct packed {
    logic [7:0]   cfg7;
    logic [7:0]   cfg6;
    logic [7:0]   rdata;
    radio_state_t state_q;
    gain_mode_t   mode;
    table_src_t   src;
    logic [1:0]   table_kind;
    logic         load;
    logic         locked;
    logic [5:0]   tune_a;
    logic [3:0]   tune_b;
    logic [7:0]   tx_first;
    logic [7:0]   tx_last;
  } regs_t;

  regs_t r;
  regs_t next_r;

  function automatic logic is_entry(radio_state_t prev, radio_state_t now);
    return (now == RADIO_RX || now == RADIO_TX) && (now != prev);
  endfunction

  // Address match shared by the write and read paths
  function automatic logic hits(logic [9:0] a, logic [9:0] off);
    return a == off;
  endfunction

  radio_state_t st;
  logic         entry;
  table_src_t   live_src;

  always_comb begin
    st       = radio_state_t'(radio_state_in);
    entry    = is_entry(r.state_q, st);
    live_src = table_src_t'(r.cfg7[TBL_SRC_MSB:TBL_SRC_LSB]);
    next_r   = r;
    next_r.state_q = st;
    next_r.load    = 1'b0;
    next_r.rdata   = UNMAPPED_READ;
    if (wr_in && hits(addr_in, CFG7_OFFSET)) begin
      next_r.cfg7 = wdata_in;
    end else if (wr_in && hits(addr_in, CFG6_OFFSET)) begin
      next_r.cfg6 = wdata_in;
    end
    if (rd_in && hits(addr_in, CFG7_OFFSET)) begin
      next_r.rdata = r.cfg7;
    end else if (rd_in && hits(addr_in, CFG6_OFFSET)) begin
      next_r.rdata = r.cfg6;
    end
    // Settings latched only on entry so an operation never sees a change
    if (entry) begin
      next_r.mode   = gain_mode_t'(r.cfg7[GAIN_SEL_MSB:GAIN_SEL_LSB]);
      next_r.src    = live_src;
      next_r.load   = 1'b1;
      next_r.locked = 1'b0;
      // Tunings forced to zero when unused, guarding bad software values
      if (live_src == SRC_CUSTOM_RX || live_src == SRC_CUSTOM_BOTH) begin
        next_r.tune_a = r.cfg6[TUNE_A_MSB:TUNE_A_LSB];
        next_r.tune_b = r.cfg7[TUNE_B_MSB:TUNE_B_LSB];
      end else begin
        next_r.tune_a = 6'h00;
        next_r.tune_b = 4'h0;
      end
      if (st == RADIO_RX) begin
        if (live_src[0]) begin
          next_r.table_kind = TBL_CUSTOM_RX;
        end else begin
          next_r.table_kind = TBL_ROM_NARROW;
        end
      end else begin
        if (live_src[1]) begin
          next_r.table_kind = TBL_CUSTOM_TX;
        end else begin
          next_r.table_kind = TBL_ROM_RATE;
        end
      end
    end
    if (r.state_q != RADIO_RX) begin
      next_r.locked = 1'b0;
    end else if (r.mode == GAIN_LOCK) begin
      if (preamble_det_in || (sync_det_in && preamble_err_zero_in)) begin
        next_r.locked = 1'b1;
      end
    end
    if (entry) begin
      next_r.locked = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '{cfg7: CFG7_RESET, cfg6: CFG6_RESET, rdata: UNMAPPED_READ,
             state_q: RADIO_IDLE, mode: GAIN_FREE, src: SRC_ROM_BOTH,
             table_kind: TBL_ROM_NARROW, load: 1'b0, locked: 1'b0,
             tune_a: 6'h00, tune_b: 4'h0, tx_first: TX_TABLE_FIRST,
             tx_last: TX_TABLE_LAST};
    end else begin
      r <= next_r;
    end
  end

  assign rdata_out          = r.rdata;
  assign gain_mode_out      = r.mode;
  assign gain_lock_out      = r.locked;
  assign loop_table_out     = r.table_kind;
  assign table_load_out     = r.load;
  assign tx_table_first_out = r.tx_first;
  assign tx_table_last_out  = r.tx_last;
  assign rx_tune_a_out      = r.tune_a;
  assign rx_tune_b_out      = r.tune_b;

  sequence s_entry_rx;
    radio_state_in == 2'b01 && r.state_q != RADIO_RX;
  endsequence

  sequence s_entry_tx;
    radio_state_in == 2'b10 && r.state_q != RADIO_TX;
  endsequence

  a_load_on_entry: assert property (@(posedge clk_in) disable iff (srst_in)
    (s_entry_rx or (radio_state_in == 2'b10 && r.state_q != RADIO_TX))
    |=> table_load_out)
    else $error("table load missing on entry");

  a_rom_rx_narrow: assert property (@(posedge clk_in) disable iff (srst_in)
    s_entry_rx ##0 (r.cfg7[4] == 1'b0) |=> loop_table_out == 2'b00)
    else $error("receive not using ROM narrow table");

  a_custom_rx_table: assert property (@(posedge clk_in) disable iff (srst_in)
    s_entry_rx ##0 (r.cfg7[4] == 1'b1) |=> loop_table_out == 2'b10)
    else $error("custom receive table not selected");

  a_tx_table_src: assert property (@(posedge clk_in) disable iff (srst_in)
    (radio_state_in == 2'b10 && r.state_q != RADIO_TX && r.cfg7[5])
    |=> loop_table_out == 2'b11)
    else $error("custom transmit table not selected");

  a_tune_b_gate: assert property (@(posedge clk_in) disable iff (srst_in)
    table_load_out && !r.src[0] |-> rx_tune_b_out == 4'h0)
    else $error("tuning B applied with ROM receive table");

  a_tune_b_apply: assert property (@(posedge clk_in) disable iff (srst_in)
    s_entry_rx ##0 r.cfg7[4] |=> rx_tune_b_out == $past(r.cfg7[3:0]))
    else $error("tuning B not applied");

  a_tune_a_apply: assert property (@(posedge clk_in) disable iff (srst_in)
    s_entry_rx ##0 r.cfg7[4] |=> rx_tune_a_out == $past(r.cfg6[7:2]))
    else $error("tuning A not applied");

  a_mode_stable: assert property (@(posedge clk_in) disable iff (srst_in)
    !table_load_out && $past(!table_load_out) |-> $stable(gain_mode_out))
    else $error("gain mode changed mid operation");

  a_sync_lock: assert property (@(posedge clk_in) disable iff (srst_in)
    (r.state_q == RADIO_RX && radio_state_in == 2'b01 && r.mode == GAIN_LOCK
     && sync_det_in && !preamble_det_in && !preamble_err_zero_in && !r.locked)
    |=> !gain_lock_out)
    else $error("locked on sync with nonzero preamble allowance");

  a_gain_lock: assert property (@(posedge clk_in) disable iff (srst_in)
    gain_lock_out |-> gain_mode_out == 2'b11)
    else $error("gain locked outside lock mode");

  // Back to back entries may pulse again, so only a settled state counts
  a_load_single: assert property (@(posedge clk_in) disable iff (srst_in)
    table_load_out && radio_state_in == r.state_q |=> !table_load_out)
    else $error("table load longer than one cycle");

  a_load_only_entry: assert property (@(posedge clk_in) disable iff (srst_in)
    !entry |=> !table_load_out)
    else $error("table load without state entry");

  a_tx_rom_rate: assert property (@(posedge clk_in) disable iff (srst_in)
    s_entry_tx ##0 !r.cfg7[5] |=> loop_table_out == 2'b01)
    else $error("transmit not using ROM rate table");

  a_src0_rx_rom: assert property (@(posedge clk_in) disable iff (srst_in)
    s_entry_rx ##0 (r.cfg7[5:4] == 2'b00) |=> loop_table_out == 2'b00)
    else $error("source 0 receive not from ROM");

  a_src0_tx_rom: assert property (@(posedge clk_in) disable iff (srst_in)
    s_entry_tx ##0 (r.cfg7[5:4] == 2'b00) |=> loop_table_out == 2'b01)
    else $error("source 0 transmit not from ROM");

  a_src1_tx_rom: assert property (@(posedge clk_in) disable iff (srst_in)
    s_entry_tx ##0 (r.cfg7[5:4] == 2'b01) |=> loop_table_out == 2'b01)
    else $error("source 1 transmit not from ROM");

  a_src2_rx_rom: assert property (@(posedge clk_in) disable iff (srst_in)
    s_entry_rx ##0 (r.cfg7[5:4] == 2'b10) |=> loop_table_out == 2'b00)
    else $error("source 2 receive not from ROM");

  a_src3_rx_custom: assert property (@(posedge clk_in) disable iff (srst_in)
    s_entry_rx ##0 (r.cfg7[5:4] == 2'b11) |=> loop_table_out == 2'b10)
    else $error("source 3 receive table not custom");

  a_src3_tx_custom: assert property (@(posedge clk_in) disable iff (srst_in)
    s_entry_tx ##0 (r.cfg7[5:4] == 2'b11) |=> loop_table_out == 2'b11)
    else $error("source 3 transmit table not custom");

  a_mode_latch: assert property (@(posedge clk_in) disable iff (srst_in)
    entry |=> gain_mode_out == $past(r.cfg7[7:6]))
    else $error("gain mode not taken on entry");

  a_src_latch: assert property (@(posedge clk_in) disable iff (srst_in)
    entry |=> r.src == $past(r.cfg7[5:4]))
    else $error("table source not taken on entry");

  a_tune_a_gate: assert property (@(posedge clk_in) disable iff (srst_in)
    table_load_out && !r.src[0] |-> rx_tune_a_out == 6'h00)
    else $error("tuning A applied with ROM receive table");

  a_tune_b_tx: assert property (@(posedge clk_in) disable iff (srst_in)
    s_entry_tx ##0 r.cfg7[4] |=> rx_tune_b_out == $past(r.cfg7[3:0]))
    else $error("tuning B not applied on transmit entry");

  a_tune_a_tx: assert property (@(posedge clk_in) disable iff (srst_in)
    s_entry_tx ##0 r.cfg7[4] |=> rx_tune_a_out == $past(r.cfg6[7:2]))
    else $error("tuning A not applied on transmit entry");

  a_preamble_lock: assert property (@(posedge clk_in) disable iff (srst_in)
    (r.state_q == RADIO_RX && radio_state_in == 2'b01
     && r.mode == GAIN_LOCK && preamble_det_in)
    |=> gain_lock_out)
    else $error("no lock after preamble");

  a_sync_lock_ok: assert property (@(posedge clk_in) disable iff (srst_in)
    (r.state_q == RADIO_RX && radio_state_in == 2'b01
     && r.mode == GAIN_LOCK && sync_det_in && preamble_err_zero_in)
    |=> gain_lock_out)
    else $error("no lock after sync with zero allowance");

  a_lock_leave: assert property (@(posedge clk_in) disable iff (srst_in)
    r.state_q != RADIO_RX |=> !gain_lock_out)
    else $error("lock kept outside receive");

  a_lock_other_mode: assert property (@(posedge clk_in) disable iff (srst_in)
    r.mode != GAIN_LOCK && !gain_lock_out |=> !gain_lock_out)
    else $error("lock set outside lock mode");

  a_table_window: assert property (@(posedge clk_in) disable iff (srst_in)
    tx_table_first_out == TX_TABLE_FIRST
    && tx_table_last_out == TX_TABLE_LAST)
    else $error("transmit table window wrong");

  a_rdata_cfg7: assert property (@(posedge clk_in) disable iff (srst_in)
    rd_in && addr_in == CFG7_OFFSET |=> rdata_out == $past(r.cfg7))
    else $error("read of gain and table register wrong");

  a_rdata_cfg6: assert property (@(posedge clk_in) disable iff (srst_in)
    rd_in && addr_in == CFG6_OFFSET |=> rdata_out == $past(r.cfg6))
    else $error("read of tuning A register wrong");

  a_rdata_idle: assert property (@(posedge clk_in) disable iff (srst_in)
    !rd_in |=> rdata_out == UNMAPPED_READ)
    else $error("read data without read strobe");

  // Writes in mid operation must not reach the live table or tuning
  a_write_held: assert property (@(posedge clk_in) disable iff (srst_in)
    !entry |=> $stable(loop_table_out) && $stable(rx_tune_b_out))
    else $error("table changed without entry");

endmodule // gain_synth_cfg

// ### gain_synth_pkg.sv
// Constants for the gain lock and synthesizer table configuration block
package gain_synth_pkg;
  localparam logic [9:0] CFG7_OFFSET      = 10'h113;
  localparam logic [9:0] CFG6_OFFSET      = 10'h112;
  localparam logic [7:0] CFG7_RESET       = 8'h00;
  localparam logic [7:0] CFG6_RESET       = 8'h00;
  localparam int         GAIN_SEL_MSB     = 7;
  localparam int         GAIN_SEL_LSB     = 6;
  localparam int         TBL_SRC_MSB      = 5;
  localparam int         TBL_SRC_LSB      = 4;
  localparam int         TUNE_B_MSB       = 3;
  localparam int         TUNE_B_LSB       = 0;
  localparam int         TUNE_A_MSB       = 7;
  localparam int         TUNE_A_LSB       = 2;
  localparam logic [7:0] TX_TABLE_FIRST   = 8'h10;
  localparam logic [7:0] TX_TABLE_LAST    = 8'h18;
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;

  typedef enum logic [1:0] {
    GAIN_FREE   = 2'b00,
    GAIN_MANUAL = 2'b01,
    GAIN_HOLD   = 2'b10,
    GAIN_LOCK   = 2'b11
  } gain_mode_t;

  typedef enum logic [1:0] {
    SRC_ROM_BOTH  = 2'b00,
    SRC_CUSTOM_RX = 2'b01,
    SRC_CUSTOM_TX = 2'b10,
    SRC_CUSTOM_BOTH = 2'b11
  } table_src_t;

  typedef enum logic [1:0] {
    TBL_ROM_NARROW = 2'b00,
    TBL_ROM_RATE   = 2'b01,
    TBL_CUSTOM_RX  = 2'b10,
    TBL_CUSTOM_TX  = 2'b11
  } table_kind_t;

  typedef enum logic [1:0] {
    RADIO_IDLE  = 2'b00,
    RADIO_RX    = 2'b01,
    RADIO_TX    = 2'b10,
    RADIO_SLEEP = 2'b11
  } radio_state_t;
endpackage

// ### radio_gain_lock_synth_table_cfg_bench.sv
// Self-checking bench for the gain lock and synth table config block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_errors++; $display("Error %s exp %h got %h", nm, (e), (g)); end end
module radio_gain_lock_synth_table_cfg_bench
  import gain_synth_pkg::*;
();
  logic       clk_in = 0, srst_in = 1, wr = 0, rd = 0;
  logic       pez = 0, pre = 0, syn = 0, gl, ld;
  logic [9:0] addr = 0;
  logic [7:0] wdata = 0, rdata, tf, tl;
  logic [1:0] st = 0, gm, lt;
  logic [5:0] ta;
  logic [3:0] tb;
  int         n_errors = 0, n_compared = 0;

  gain_synth_cfg u_gain_synth_cfg (.clk_in(clk_in), .srst_in(srst_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .radio_state_in(st), .preamble_err_zero_in(pez),
    .preamble_det_in(pre), .sync_det_in(syn), .gain_mode_out(gm),
    .gain_lock_out(gl), .loop_table_out(lt), .table_load_out(ld),
    .tx_table_first_out(tf), .tx_table_last_out(tl),
    .rx_tune_a_out(ta), .rx_tune_b_out(tb));

  initial begin
    forever #4 clk_in = ~clk_in;
  end

  task wr8(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_in) begin wr <= 1; addr <= a; wdata <= d; end
    @(posedge clk_in) wr <= 0;
  endtask

  task rd8(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk_in) begin rd <= 1; addr <= a; end
    @(posedge clk_in) rd <= 0;
    #1 `CHK("rdata", e, rdata)
  endtask

  // Idle first so every call is a fresh entry
  task enter(input logic [1:0] s, input logic [7:0] c7, input logic [5:0] a);
    logic [1:0] src;
    src = c7[5:4];
    wr8(CFG6_OFFSET, {a, 2'b00});
    wr8(CFG7_OFFSET, c7);
    @(posedge clk_in) st <= RADIO_IDLE;
    @(posedge clk_in) st <= s;
    @(posedge clk_in) #1;
    `CHK("load", 1'b1, ld)
    `CHK("mode", c7[7:6], gm)
    `CHK("tune_b", src[0] ? c7[3:0] : 4'h0, tb)
    `CHK("tune_a", src[0] ? a : 6'h00, ta)
    if (s == RADIO_RX)
      `CHK("rx_table", src[0] ? TBL_CUSTOM_RX : TBL_ROM_NARROW, lt)
    else
      `CHK("tx_table", src[1] ? TBL_CUSTOM_TX : TBL_ROM_RATE, lt)
    @(posedge clk_in) #1;
    `CHK("load_end", 1'b0, ld)
  endtask

  task det(input logic p, input logic s, input logic z, input logic e);
    @(posedge clk_in) begin pre <= p; syn <= s; pez <= z; end
    @(posedge clk_in) begin pre <= 0; syn <= 0; end
    #1 `CHK("lock", e, gl)
  endtask

  task t_regs;
    rd8(CFG7_OFFSET, CFG7_RESET);
    rd8(CFG6_OFFSET, CFG6_RESET);
    wr8(CFG7_OFFSET, 8'hf5);
    rd8(CFG7_OFFSET, 8'hf5);
    wr8(10'h000, 8'hff);
    rd8(10'h000, UNMAPPED_READ);
    `CHK("tx_first", TX_TABLE_FIRST, tf)
    `CHK("tx_last", TX_TABLE_LAST, tl)
  endtask

  // Every source in both states, every gain mode once in each state
  task t_tables;
    for (int i = 0; i < 4; i++) begin
      enter(RADIO_RX, {2'(3 - i), 2'(i), i[0] ? 4'h5 : 4'h0},
            i[0] ? 6'h2a : 6'h00);
      enter(RADIO_TX, {2'(i), 2'(i), i[0] ? 4'ha : 4'h0},
            i[0] ? 6'h15 : 6'h00);
    end
  endtask

  // Mid-operation writes must wait for the next entry
  task t_hold;
    enter(RADIO_RX, 8'h1c, 6'h01);
    wr8(CFG7_OFFSET, 8'h00);
    repeat (2) @(posedge clk_in);
    #1 `CHK("held_table", TBL_CUSTOM_RX, lt)
    `CHK("held_tune", 4'hc, tb)
  endtask

  task t_lock;
    enter(RADIO_RX, 8'hc0, 6'h00);
    det(1'b0, 1'b1, 1'b0, 1'b0);
    det(1'b0, 1'b1, 1'b1, 1'b1);
    enter(RADIO_RX, 8'h80, 6'h00);
    det(1'b1, 1'b0, 1'b0, 1'b0);
    enter(RADIO_RX, 8'hc0, 6'h00);
    det(1'b1, 1'b0, 1'b0, 1'b1);
  endtask

  // Custom transmit table rewritten by software after each wake
  task t_sleep;
    enter(RADIO_TX, 8'h20, 6'h00);
    @(posedge clk_in) st <= RADIO_SLEEP;
    enter(RADIO_TX, 8'h20, 6'h00);
  endtask

  task complete_run;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    srst_in <= 0;
    t_regs;
    t_tables;
    t_hold;
    t_lock;
    t_sleep;
    complete_run;
  end

  // Whole run is about 140 cycles
  initial begin
    repeat (5000) @(posedge clk_in);
    n_errors++;
    complete_run;
  end
endmodule // radio_gain_lock_synth_table_cfg_bench
